// ===== common/fcs_pkg.sv
// Purpose: shared constants, types and carriers for the flash command host
// Assumes: 100 MHz system clock, byte-wide parallel flash with unlock commands
// Notes:   every timing count is derived from the printed time and the clock
package fcs_pkg;

  // clock and printed times
  localparam int CLK_NS  = 10;   // clock period
  localparam int TWP_NS  = 100;  // least write strobe low time
  localparam int TWPH_NS = 100;  // least write strobe high time
  localparam int TACC_NS = 120;  // slowest read access time
  localparam int TRST_NS = 500;  // least reset pin low time
  localparam int TID_US  = 10;   // pause after id entry
  localparam int TBP_US  = 50;   // longest byte program time
  localparam int TEC_MS  = 200;  // longest erase time

  // derived cycle counts: least times and the access time round up, program and erase times round down
  localparam int TWP_CYC  = (TWP_NS + CLK_NS - 1) / CLK_NS;
  localparam int TWPH_CYC = (TWPH_NS + CLK_NS - 1) / CLK_NS;
  localparam int TACC_CYC = (TACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int TRST_CYC = (TRST_NS + CLK_NS - 1) / CLK_NS;
  localparam int TID_CYC  = (TID_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int TBP_CYC  = (TBP_US * 1000) / CLK_NS;
  localparam int TEC_CYC  = (TEC_MS * 1000000) / CLK_NS;

  // command addresses and codes
  localparam logic [14:0] UNLOCK_A  = 15'h5555;
  localparam logic [14:0] UNLOCK_B  = 15'h2AAA;
  localparam logic [7:0]  DATA_AA   = 8'hAA;
  localparam logic [7:0]  DATA_55   = 8'h55;
  localparam logic [7:0]  CODE_PROG = 8'hA0;
  localparam logic [7:0]  CODE_ERS  = 8'h80;
  localparam logic [7:0]  CODE_CHIP = 8'h10;
  localparam logic [7:0]  CODE_SECT = 8'h30;
  localparam logic [7:0]  CODE_LOCK = 8'h40;
  localparam logic [7:0]  CODE_IDIN = 8'h90;
  localparam logic [7:0]  CODE_EXIT = 8'hF0;

  // identification addresses
  localparam logic [17:0] ID_MAKER_ADDR = 18'h00000;
  localparam logic [17:0] ID_PART_ADDR  = 18'h00001;
  localparam logic [17:0] ID_LOCK_ADDR  = 18'h00002;

  // erase block bases (each block runs up to the next base)
  localparam logic [17:0] BOOT_BASE  = 18'h3C000;
  localparam logic [17:0] PB1_BASE   = 18'h3A000;
  localparam logic [17:0] PB2_BASE   = 18'h38000;
  localparam logic [17:0] MAIN1_BASE = 18'h20000;

  // status bit positions on the data lines
  localparam int LOCK_BIT   = 0;
  localparam int TOGGLE_BIT = 6;
  localparam int POLL_BIT   = 7;

  // host commands
  typedef enum logic [2:0] {
    FCS_READ, FCS_PROGRAM, FCS_CHIP_ERASE, FCS_SECTOR_ERASE,
    FCS_LOCKOUT, FCS_ID_ENTRY, FCS_ID_EXIT3, FCS_ID_EXIT1
  } fcs_cmd_t;

  // block hit by the last erase
  typedef enum logic [2:0] {
    BLK_NONE, BLK_CHIP, BLK_BOOT, BLK_PARAM1, BLK_PARAM2, BLK_MAIN1, BLK_MAIN2
  } fcs_block_t;

  // one request from the user side
  typedef struct packed {
    fcs_cmd_t    cmd;
    logic [17:0] addr;
    logic [7:0]  data;
  } fcs_req_t;

  // flash pin outputs, every control line active-low
  typedef struct packed {
    logic        reset_n;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [17:0] addr;
    logic [7:0]  dout;
    logic        dout_en_n;
  } fcs_pins_t;

endpackage

// ===== design/fcs_bus_cycle.sv
// Purpose: one write or read cycle on the flash pins, plus power-on reset pulse
// Assumes: ce_i freezes everything; data_lines_i is asynchronous to clk_i
// Notes:   all pin outputs are flip-flops; data stays driven past the strobe
`timescale 1ns/1ns
module fcs_bus_cycle
  import fcs_pkg::*;
(
  input  wire logic        clk_i,         // system clock
  input  wire logic        rst_i,         // async reset, active high
  input  wire logic        ce_i,          // clock enable
  input  wire logic        start_i,       // start one cycle, pulse
  input  wire logic        wr_i,          // 1 write, 0 read
  input  wire logic [17:0] addr_i,        // cycle address
  input  wire logic [7:0]  wdata_i,       // write data
  input  wire logic [7:0]  data_lines_i,  // data lines from the flash
  output logic             idle_o,        // ready for start_i
  output logic             done_o,        // cycle finished, pulse
  output logic [7:0]       rdata_o,       // captured read data
  output fcs_pins_t        pins_o         // flash pins
);

  typedef enum logic [2:0] {B_RST, B_IDLE, B_SETUP, B_STROBE, B_RECOV} fcs_bus_st_t;

  fcs_bus_st_t st_ff;          // cycle phase
  logic        wr_ff;          // current cycle is a write
  logic [7:0]  cnt_ff;         // phase counter
  logic [7:0]  sync1_ff;       // first sync stage, read only by sync2
  logic [7:0]  sync2_ff;       // second sync stage
  logic [7:0]  strobe_end;     // last strobe cycle
  logic [7:0]  we_low_cnt_ff;  // helper for the strobe width check

  // reads wait two extra cycles for the synchroniser
  assign strobe_end = wr_ff ? 8'(TWP_CYC - 1) : 8'(TACC_CYC + 1);

  // sequence and pins: one process so pins change only at phase edges
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_ff  <= B_RST;
      wr_ff  <= 1'b0;
      cnt_ff <= 8'h00;
      idle_o <= 1'b0;
      done_o <= 1'b0;
      pins_o <= '{reset_n: 1'b0, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                  addr: 18'h00000, dout: 8'h00, dout_en_n: 1'b1};
    end
    else if (ce_i)
    begin
      done_o <= 1'b0;
      case (st_ff)
        B_RST:
        begin
          // flash reset pin held low long enough to abort anything running
          if (cnt_ff == 8'(TRST_CYC - 1))
          begin
            pins_o.reset_n <= 1'b1;
            st_ff          <= B_IDLE;
            idle_o         <= 1'b1;
            cnt_ff         <= 8'h00;
          end
          else
            cnt_ff <= cnt_ff + 8'h01;
        end
        B_IDLE:
        begin
          if (start_i)
          begin
            // address and data set up before any strobe falls
            wr_ff            <= wr_i;
            idle_o           <= 1'b0;
            pins_o.addr      <= addr_i;
            pins_o.dout      <= wdata_i;
            pins_o.dout_en_n <= ~wr_i;
            pins_o.ce_n      <= 1'b0;
            st_ff            <= B_SETUP;
          end
        end
        B_SETUP:
        begin
          // write enable never meets output enable
          pins_o.we_n <= ~wr_ff;
          pins_o.oe_n <= wr_ff;
          cnt_ff      <= 8'h00;
          st_ff       <= B_STROBE;
        end
        B_STROBE:
        begin
          if (cnt_ff == strobe_end)
          begin
            pins_o.we_n <= 1'b1;
            pins_o.oe_n <= 1'b1;
            cnt_ff      <= 8'h00;
            st_ff       <= B_RECOV;
          end
          else
            cnt_ff <= cnt_ff + 8'h01;
        end
        B_RECOV:
        begin
          // recovery doubles as data and address hold after the strobe
          if (cnt_ff == 8'(TWPH_CYC - 1))
          begin
            pins_o.ce_n      <= 1'b1;
            pins_o.dout_en_n <= 1'b1;
            done_o           <= 1'b1;
            idle_o           <= 1'b1;
            st_ff            <= B_IDLE;
          end
          else
            cnt_ff <= cnt_ff + 8'h01;
        end
        default:
          st_ff <= B_RST;
      endcase
    end
  end

  // two-stage synchroniser on the data lines
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
    end
    else if (ce_i)
    begin
      sync1_ff <= data_lines_i;
      sync2_ff <= sync1_ff;
    end
  end

  // capture read data on the last strobe cycle
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= 8'h00;
    else if (ce_i && st_ff == B_STROBE && !wr_ff && cnt_ff == strobe_end)
      rdata_o <= sync2_ff;
  end

  // helper: enabled cycles with write enable low
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      we_low_cnt_ff <= 8'h00;
    else if (ce_i)
      we_low_cnt_ff <= pins_o.we_n ? 8'h00 : we_low_cnt_ff + 8'h01;
  end

  we_width_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(pins_o.we_n) |-> we_low_cnt_ff >= 8'(TWP_CYC))
    else $error("write strobe shorter than least width");
  no_dual_strobe_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(!pins_o.we_n && !pins_o.oe_n))
    else $error("write and output enable low together");
  drive_on_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !pins_o.we_n |-> (!pins_o.dout_en_n && !pins_o.ce_n))
    else $error("write strobe without driven data or chip enable");
  release_after_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(pins_o.ce_n) |-> (pins_o.dout_en_n && pins_o.we_n && pins_o.oe_n))
    else $error("chip deselected while still driving or strobing");

endmodule

// ===== design/fcs_host.sv
// Purpose: host sequencer issuing unlock command sequences to a parallel flash
// Assumes: one request at a time; flash pins are driven by fcs_bus_cycle
// Notes:   completion of program and erase is found by status polling
`timescale 1ns/1ns
module fcs_host
  import fcs_pkg::*;
#(
  parameter int TBP_CYCLES = TBP_CYC,  // program time limit in cycles
  parameter int TEC_CYCLES = TEC_CYC   // erase time limit in cycles
)(
  input  wire logic        clk_i,         // system clock
  input  wire logic        rst_i,         // async reset, active high
  input  wire logic        ce_i,          // clock enable
  input  wire logic        req_valid_i,   // request offered
  input  fcs_req_t         req_i,         // request body
  input  wire logic [7:0]  data_lines_i,  // data lines from the flash
  output logic             req_ready_o,   // request accepted when high
  output logic             resp_valid_o,  // request finished, pulse
  output logic [7:0]       resp_data_o,   // read data
  output logic             resp_fail_o,   // timeout or status mismatch
  output logic             lockout_o,     // last seen boot lockout status
  output logic             id_mode_o,     // flash is in identification mode
  output fcs_block_t       erase_block_o, // block hit by the last erase
  output fcs_pins_t        pins_o         // flash pins
);

  if (TBP_CYCLES < 1 || TEC_CYCLES < 1 || TBP_CYCLES > TEC_CYCLES)
  begin : g_bad_limits
    $error("fcs_host: time limits must be positive and program below erase");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_ISSUE, ST_WAIT, ST_PAUSE, ST_POLL, ST_PWAIT, ST_REPLY
  } fcs_st_t;

  fcs_st_t     st_ff;        // sequencer state
  fcs_req_t    req_ff;       // request in progress
  logic [2:0]  step_ff;      // index of the next write
  logic [17:0] last_addr_ff; // address of the last write, polled
  logic [31:0] cnt_ff;       // pause or timeout counter
  logic        have_prev_ff; // one poll read already taken
  logic        prev6_ff;     // toggle bit of the previous poll
  logic        bus_start_ff; // start pulse to the bus unit
  logic        bus_wr_ff;    // bus cycle direction
  logic [17:0] bus_addr_ff;  // bus cycle address
  logic [7:0]  bus_wdata_ff; // bus cycle data
  logic        bus_idle;     // bus unit ready
  logic        bus_done;     // bus cycle finished
  logic [7:0]  bus_rdata;    // bus read data
  logic [25:0] word;         // address and data of the current step
  logic [2:0]  n_writes;     // writes in the current command
  logic [31:0] tmo_limit;    // polling limit for the current command
  logic        exp7;         // expected true bit 7 after completion
  logic [31:0] gap_cnt_ff;   // helper: cycles since the last write ended

  // number of writes per command
  always_comb
  begin
    case (req_ff.cmd)
      FCS_PROGRAM:                              n_writes = 3'd4;
      FCS_CHIP_ERASE, FCS_SECTOR_ERASE, FCS_LOCKOUT: n_writes = 3'd6;
      FCS_ID_ENTRY, FCS_ID_EXIT3:               n_writes = 3'd3;
      FCS_ID_EXIT1:                             n_writes = 3'd1;
      default:                                  n_writes = 3'd0;
    endcase
  end

  // address and data of step step_ff; unlock addresses drive upper bits low
  always_comb
  begin
    case (step_ff)
      3'd0:    word = {3'h0, UNLOCK_A, DATA_AA};
      3'd1:    word = {3'h0, UNLOCK_B, DATA_55};
      3'd2:    word = {3'h0, UNLOCK_A, CODE_ERS};
      3'd3:    word = {3'h0, UNLOCK_A, DATA_AA};
      3'd4:    word = {3'h0, UNLOCK_B, DATA_55};
      default: word = {3'h0, UNLOCK_A, CODE_CHIP};
    endcase
    if (step_ff == 3'd2)
    begin
      case (req_ff.cmd)
        FCS_PROGRAM:  word[7:0] = CODE_PROG;
        FCS_ID_ENTRY: word[7:0] = CODE_IDIN;
        FCS_ID_EXIT3: word[7:0] = CODE_EXIT;
        default:      word[7:0] = CODE_ERS;
      endcase
    end
    if (req_ff.cmd == FCS_PROGRAM && step_ff == 3'd3)
      word = {req_ff.addr, req_ff.data};
    if (req_ff.cmd == FCS_SECTOR_ERASE && step_ff == 3'd5)
      word = {req_ff.addr, CODE_SECT};
    if (req_ff.cmd == FCS_LOCKOUT && step_ff == 3'd5)
      word[7:0] = CODE_LOCK;
    if (req_ff.cmd == FCS_ID_EXIT1)
      word = {req_ff.addr, CODE_EXIT};
  end

  // erases report done through the erase limit, programs through their own
  assign tmo_limit = (req_ff.cmd == FCS_PROGRAM) ? 32'(TBP_CYCLES) : 32'(TEC_CYCLES);
  assign exp7      = (req_ff.cmd == FCS_PROGRAM) ? req_ff.data[POLL_BIT] : 1'b1;

  // main sequencer
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_ff        <= ST_IDLE;
      req_ff       <= '{cmd: FCS_READ, addr: 18'h00000, data: 8'h00};
      step_ff      <= 3'd0;
      last_addr_ff <= 18'h00000;
      cnt_ff       <= 32'h0000_0000;
      have_prev_ff <= 1'b0;
      prev6_ff     <= 1'b0;
      bus_start_ff <= 1'b0;
      bus_wr_ff    <= 1'b0;
      bus_addr_ff  <= 18'h00000;
      bus_wdata_ff <= 8'h00;
      req_ready_o  <= 1'b0;
      resp_valid_o <= 1'b0;
      resp_data_o  <= 8'h00;
      resp_fail_o  <= 1'b0;
    end
    else if (ce_i)
    begin
      bus_start_ff <= 1'b0;
      resp_valid_o <= 1'b0;
      case (st_ff)
        ST_IDLE:
        begin
          // ready only once the bus unit has finished its reset pulse
          req_ready_o <= bus_idle;
          if (req_valid_i && req_ready_o)
          begin
            req_ff      <= req_i;
            req_ready_o <= 1'b0;
            step_ff     <= 3'd0;
            resp_fail_o <= 1'b0;
            st_ff       <= ST_ISSUE;
          end
        end
        ST_ISSUE:
        begin
          bus_start_ff <= 1'b1;
          bus_wr_ff    <= (req_ff.cmd != FCS_READ);
          bus_addr_ff  <= (req_ff.cmd == FCS_READ) ? req_ff.addr : word[25:8];
          bus_wdata_ff <= word[7:0];
          last_addr_ff <= word[25:8];
          st_ff        <= ST_WAIT;
        end
        ST_WAIT:
        begin
          if (bus_done)
          begin
            if (req_ff.cmd == FCS_READ)
            begin
              resp_data_o <= bus_rdata;
              st_ff       <= ST_REPLY;
            end
            else if (step_ff + 3'd1 < n_writes)
            begin
              step_ff <= step_ff + 3'd1;
              st_ff   <= ST_ISSUE;
            end
            else
            begin
              cnt_ff       <= 32'h0000_0000;
              have_prev_ff <= 1'b0;
              case (req_ff.cmd)
                FCS_PROGRAM, FCS_CHIP_ERASE, FCS_SECTOR_ERASE: st_ff <= ST_POLL;
                FCS_LOCKOUT:  st_ff <= ST_PAUSE;
                FCS_ID_ENTRY: st_ff <= ST_PAUSE;
                default:      st_ff <= ST_REPLY;
              endcase
            end
          end
        end
        ST_PAUSE:
        begin
          // lockout waits a program time, id entry its settling pause
          if (cnt_ff == ((req_ff.cmd == FCS_LOCKOUT) ? 32'(TBP_CYCLES - 1)
                                                      : 32'(TID_CYC - 1)))
            st_ff <= ST_REPLY;
          else
            cnt_ff <= cnt_ff + 32'h1;
        end
        ST_POLL:
        begin
          // status read at the last written address
          bus_start_ff <= 1'b1;
          bus_wr_ff    <= 1'b0;
          bus_addr_ff  <= last_addr_ff;
          cnt_ff       <= cnt_ff + 32'h1;
          st_ff        <= ST_PWAIT;
        end
        ST_PWAIT:
        begin
          cnt_ff <= cnt_ff + 32'h1;
          if (bus_done)
          begin
            if (have_prev_ff && bus_rdata[TOGGLE_BIT] == prev6_ff)
            begin
              // toggling stopped; a true bit 7 mismatch means nothing was
              // written, as with a locked boot sector erase
              resp_data_o <= bus_rdata;
              resp_fail_o <= (bus_rdata[POLL_BIT] != exp7);
              st_ff       <= ST_REPLY;
            end
            else if (cnt_ff >= tmo_limit)
            begin
              resp_data_o <= bus_rdata;
              resp_fail_o <= 1'b1;
              st_ff       <= ST_REPLY;
            end
            else
            begin
              prev6_ff     <= bus_rdata[TOGGLE_BIT];
              have_prev_ff <= 1'b1;
              st_ff        <= ST_POLL;
            end
          end
        end
        ST_REPLY:
        begin
          resp_valid_o <= 1'b1;
          st_ff        <= ST_IDLE;
        end
        default:
          st_ff <= ST_IDLE;
      endcase
    end
  end

  // identification mode and lockout status tracking; reset means power-up
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      id_mode_o <= 1'b0;
      lockout_o <= 1'b0;
    end
    else if (ce_i && st_ff == ST_REPLY)
    begin
      if (req_ff.cmd == FCS_ID_ENTRY)
        id_mode_o <= 1'b1;
      else if (req_ff.cmd == FCS_ID_EXIT3 || req_ff.cmd == FCS_ID_EXIT1)
        id_mode_o <= 1'b0;
      else if (req_ff.cmd == FCS_LOCKOUT)
        lockout_o <= 1'b1;
      else if (req_ff.cmd == FCS_READ && id_mode_o && req_ff.addr == ID_LOCK_ADDR)
        lockout_o <= resp_data_o[LOCK_BIT];
    end
  end

  // block decode of the erase just launched
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      erase_block_o <= BLK_NONE;
    else if (ce_i && st_ff == ST_REPLY)
    begin
      if (req_ff.cmd == FCS_CHIP_ERASE)
        erase_block_o <= BLK_CHIP;
      else if (req_ff.cmd == FCS_SECTOR_ERASE)
      begin
        if (req_ff.addr >= BOOT_BASE)
          erase_block_o <= resp_fail_o ? BLK_NONE : BLK_BOOT;
        else if (req_ff.addr >= PB1_BASE)
          erase_block_o <= BLK_PARAM1;
        else if (req_ff.addr >= PB2_BASE)
          erase_block_o <= BLK_PARAM2;
        else if (req_ff.addr >= MAIN1_BASE)
          erase_block_o <= BLK_MAIN1;
        else
          erase_block_o <= BLK_MAIN2;
      end
    end
  end

  fcs_bus_cycle fcs_bus_cycle_inst (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .ce_i         (ce_i),
    .start_i      (bus_start_ff),
    .wr_i         (bus_wr_ff),
    .addr_i       (bus_addr_ff),
    .wdata_i      (bus_wdata_ff),
    .data_lines_i (data_lines_i),
    .idle_o       (bus_idle),
    .done_o       (bus_done),
    .rdata_o      (bus_rdata),
    .pins_o       (pins_o)
  );

  // helper: enabled cycles since the last write cycle completed
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      gap_cnt_ff <= 32'h0000_0000;
    else if (ce_i)
      gap_cnt_ff <= (bus_done && bus_wr_ff) ? 32'h0000_0000 : gap_cnt_ff + 32'h1;
  end

  unlock_first_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_start_ff && bus_wr_ff && step_ff == 3'd0 && req_ff.cmd != FCS_ID_EXIT1)
    |-> (bus_addr_ff[14:0] == UNLOCK_A && bus_wdata_ff == DATA_AA))
    else $error("first unlock write wrong");
  chip_final_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_start_ff && bus_wr_ff && step_ff == 3'd5 && req_ff.cmd == FCS_CHIP_ERASE)
    |-> (bus_addr_ff[14:0] == UNLOCK_A && bus_wdata_ff == CODE_CHIP))
    else $error("chip erase final write wrong");
  sector_final_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_start_ff && bus_wr_ff && step_ff == 3'd5 && req_ff.cmd == FCS_SECTOR_ERASE)
    |-> (bus_addr_ff == req_ff.addr && bus_wdata_ff == CODE_SECT))
    else $error("sector erase final write wrong");
  lock_wait_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (resp_valid_o && req_ff.cmd == FCS_LOCKOUT) |-> gap_cnt_ff >= 32'(TBP_CYCLES))
    else $error("lockout answered before program time");
  id_pause_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (resp_valid_o && req_ff.cmd == FCS_ID_ENTRY) |-> gap_cnt_ff >= 32'(TID_CYC))
    else $error("id entry answered before pause");
  exit_any_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (bus_start_ff && req_ff.cmd == FCS_ID_EXIT1)
    |-> (bus_addr_ff == req_ff.addr && bus_wdata_ff == CODE_EXIT))
    else $error("single exit write wrong");

endmodule

// ===== tb/fcs_flash_model.sv
// Purpose: behavioural flash device on the host pins
// Assumes: a write lands on the rising write strobe
// Notes:   a launch answers busy to the first BUSY_RD - 1 read strobes after it
`timescale 1ns/1ns
module fcs_flash_model
  import fcs_pkg::*;
#(
  parameter logic [7:0] MAKER_ID = 8'h3C, // arbitrary value
  parameter logic [7:0] PART_ID  = 8'hC3, // arbitrary value
  parameter int         BUSY_RD  = 3      // one more than the busy status reads
)(
  input  fcs_pins_t  pins_i, // host pins
  output logic [7:0] dq_o    // data lines
);
  logic [2:0]  st_ff  = 3'h0;  // unlock step
  logic        id_ff  = 1'b0;  // power-up in normal mode
  logic        lk_ff  = 1'b0;  // boot lockout
  logic [7:0]  val_ff = 8'hFF; // array byte seen by reads
  int          rd_ff  = 0;     // read strobe count
  int          rd0_ff = -9;    // count at launch
  wire  [14:0] a      = pins_i.addr[14:0];
  wire  [7:0]  d      = pins_i.dout;
  wire         busy   = (rd_ff - rd0_ff) < BUSY_RD;
  // decoder: any stray write drops back to step zero
  always @(posedge pins_i.we_n)
    if (!pins_i.ce_n && pins_i.reset_n)
    begin
      st_ff <= 3'h0;
      case (st_ff)
        3'h0: if (d == DATA_AA && a == UNLOCK_A) st_ff <= 3'h1;
              else if (d == CODE_EXIT) id_ff <= 1'b0;
        3'h1: if (d == DATA_55 && a == UNLOCK_B) st_ff <= 3'h2;
        3'h2: if (a != UNLOCK_A) st_ff <= 3'h0;
              else if (d == CODE_PROG) st_ff <= 3'h6;
              else if (d == CODE_ERS) st_ff <= 3'h3;
              else if (d == CODE_IDIN) id_ff <= 1'b1;
              else if (d == CODE_EXIT) id_ff <= 1'b0;
        3'h3: if (d == DATA_AA && a == UNLOCK_A) st_ff <= 3'h4;
        3'h4: if (d == DATA_55 && a == UNLOCK_B) st_ff <= 3'h5;
        3'h5: if (d == CODE_LOCK && a == UNLOCK_A) lk_ff <= 1'b1;
              else if (d == CODE_SECT && pins_i.addr >= BOOT_BASE && lk_ff) val_ff <= 8'h00;
              else if (d == CODE_SECT || (d == CODE_CHIP && a == UNLOCK_A))
              begin
                val_ff <= 8'hFF;
                rd0_ff <= rd_ff;
              end
        3'h6:
        begin
          val_ff <= d;
          rd0_ff <= rd_ff;
        end
        default: st_ff <= 3'h0;
      endcase
    end
  // each read strobe steps the toggle bit
  always @(negedge pins_i.oe_n)
    if (!pins_i.ce_n)
      rd_ff <= rd_ff + 1;
  // released lines move, so a stale capture cannot pass
  always_comb
    if (pins_i.ce_n || pins_i.oe_n || !pins_i.reset_n) dq_o = 8'hA5 ^ {8{rd_ff[0]}};
    else if (busy) dq_o = {~val_ff[7], rd_ff[0], 6'h00};
    else if (id_ff && pins_i.addr[1]) dq_o = {7'h00, lk_ff};
    else if (id_ff) dq_o = pins_i.addr[0] ? PART_ID : MAKER_ID;
    else dq_o = val_ff;
endmodule

// ===== tb/tb_flash_command_sequencer.sv
// Purpose: self-checking bench for the flash command host
// Assumes: behavioural flash model on the pins
// Notes:   driver queues expectations, a watcher pops them
`timescale 1ns/1ns
module tb_flash_command_sequencer
  import fcs_pkg::*;
();
  localparam logic [7:0] MK = 8'h3C, PT = 8'hC3; // arbitrary ids
  logic        clk_i = 0, rst_i = 1, req_valid_i = 0;
  fcs_req_t    req_i = '0;
  logic [7:0]  dq, data_lines_i, resp_data_o, mem = 8'hFF;
  logic        req_ready_o, resp_valid_o, resp_fail_o, lockout_o, id_mode_o;
  logic        id = 0, lk = 0;  // expected modes
  fcs_block_t  erase_block_o, blk = BLK_NONE;
  fcs_pins_t   pins_o;
  logic [31:0] seed = 32'hCCF1;
  logic [14:0] e, exp_q[$];
  logic [17:0] top [5] = '{18'h3FFFF, 18'h3BFFF, 18'h39FFF, 18'h37FFF, 18'h1FFFF};
  int          error_cnt = 0, cmp_count = 0;
  always #5 clk_i = ~clk_i;
  assign data_lines_i = pins_o.dout_en_n ? dq : pins_o.dout; // low enable: host drives
  fcs_host #(.TBP_CYCLES(400), .TEC_CYCLES(800)) fcs_host_inst (.clk_i, .rst_i,
    .ce_i(1'b1), .req_valid_i, .req_i, .data_lines_i, .req_ready_o, .resp_valid_o,
    .resp_data_o, .resp_fail_o, .lockout_o, .id_mode_o, .erase_block_o, .pins_o);
  fcs_flash_model #(.MAKER_ID(MK), .PART_ID(PT)) fcs_flash_model_inst (.pins_i(pins_o),
    .dq_o(dq));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [13:0] got, input logic [13:0] want);
    cmp_count++;
    if (got !== want)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic final_report();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // note the outcome, then offer one request at a falling edge
  task automatic req(input fcs_cmd_t c, input logic [17:0] a, input logic [7:0] d,
                     input logic care, input logic f, input logic [7:0] v);
    exp_q.push_back({care, f, id, lk, blk, v});
    while (req_ready_o !== 1'b1) @(negedge clk_i);
    req_i = '{c, a, d};
    req_valid_i = 1;
    @(negedge clk_i);
    req_valid_i = 0;
  endtask
  // watcher: read data only counts where the note cares
  always @(negedge clk_i)
    if (resp_valid_o === 1'b1)
    begin
      e = exp_q.pop_front();
      chk({resp_fail_o, id_mode_o, lockout_o, erase_block_o, e[14] ? resp_data_o : e[7:0]},
          e[13:0]);
    end
  initial
  begin
    #300000;
    error_cnt++;
    final_report();
  end
  initial
  begin
    repeat (3) @(posedge clk_i);
    @(negedge clk_i) rst_i = 0;
    seed = lfsr(seed);
    mem = seed[7:0];
    req(FCS_PROGRAM, seed[25:8], mem, 1, 0, mem);
    req(FCS_READ, 18'h00010, 8'h00, 1, 0, mem);
    id = 1;
    req(FCS_ID_ENTRY, 18'h00000, 8'h00, 0, 0, 8'h00);
    for (int i = 0; i < 3; i++)
      req(FCS_READ, 18'(i), 8'h00, 1, 0, i == 0 ? MK : i == 1 ? PT : 8'h00);
    seed = lfsr(seed);
    id = 0;
    req(FCS_ID_EXIT1, seed[17:0], CODE_EXIT, 0, 0, 8'h00);
    req(FCS_READ, 18'h00001, 8'h00, 1, 0, mem);
    for (int i = 0; i < 5; i++)
    begin
      blk = fcs_block_t'(3'(i + 2));
      req(FCS_SECTOR_ERASE, top[i], CODE_SECT, 1, 0, 8'hFF);
    end
    blk = BLK_CHIP;
    req(FCS_CHIP_ERASE, 18'h05555, CODE_CHIP, 1, 0, 8'hFF);
    lk = 1;
    req(FCS_LOCKOUT, 18'h05555, CODE_LOCK, 0, 0, 8'h00);
    id = 1;
    req(FCS_ID_ENTRY, 18'h00000, 8'h00, 0, 0, 8'h00);
    req(FCS_READ, ID_LOCK_ADDR, 8'h00, 1, 0, 8'h01);
    id = 0;
    req(FCS_ID_EXIT3, 18'h05555, CODE_EXIT, 0, 0, 8'h00);
    blk = BLK_NONE;
    req(FCS_SECTOR_ERASE, 18'h3C000, CODE_SECT, 1, 1, 8'h00);
    while (exp_q.size() != 0) @(negedge clk_i);
    final_report();
  end
endmodule
